/* File: core/rom_host_pkg.sv */
// constants and types shared by the mask rom read host
package rom_host_pkg;

  // clock and pin timing, every figure in nanoseconds
  localparam int CLK_PERIOD_NS = 100;
  localparam int POWER_WAIT_NS = 200;
  localparam int ACCESS_NS = 90;
  localparam int FLOAT_NS = 25;
  localparam int SKEW_NS = 10;

  // least times round up to whole cycles, never below one
  localparam int POWER_WAIT_CYC_I = (POWER_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC_I = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC_I = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;

  localparam logic [2:0] POWER_WAIT_CYC = 3'(POWER_WAIT_CYC_I);
  localparam logic [2:0] READ_WAIT_CYC = 3'(ACCESS_CYC_I + SYNC_STAGES);
  localparam logic [2:0] FLOAT_CYC = 3'(FLOAT_CYC_I);
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_ONE = 3'h1;

  // pin widths
  localparam int ADDR_W = 20;
  localparam int BYTE_ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int UPPER_W = 7;
  localparam int LOW_W = 8;

  // width select levels on the mode pin
  localparam logic WIDTH_WORD = 1'b1;
  localparam logic WIDTH_BYTE = 1'b0;

  // output-gate polarity option of the fitted part
  localparam logic [1:0] GATE_OPT_LOW = 2'h0;
  localparam logic [1:0] GATE_OPT_HIGH = 2'h1;
  localparam logic [1:0] GATE_OPT_IGNORE = 2'h2;

  // reset values and the byte-read pad
  localparam logic [19:0] ADDR_RST = 20'h00000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [7:0] BYTE_PAD = 8'h00;

  typedef enum logic [2:0] {
    ST_POWER = 3'b000,
    ST_IDLE = 3'b001,
    ST_SETUP = 3'b010,
    ST_ACCESS = 3'b011,
    ST_RELEASE = 3'b100
  } host_state_t;

endpackage

/* File: core/pin_sync.sv */
// two-flop synchroniser for the data pins coming back from the rom
`timescale 1ns/1ps
module pin_sync
  import rom_host_pkg::*;
(
  input wire logic clk,                   // system clock
  input wire logic reset_n,               // async reset, active low
  input wire logic [DATA_W-1:0] pins,     // raw pin levels
  output logic [DATA_W-1:0] synced        // pin levels after two flops
);

  typedef struct packed {
    logic [DATA_W-1:0] first;
    logic [DATA_W-1:0] second;
  } sync_t;

  sync_t st;
  sync_t next_st;

  // first stage feeds only the second stage; one process keeps one driver per bit
  always_comb begin
    next_st.first = pins;
    next_st.second = st.first;
  end

  // register the whole state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign synced = st.second;

endmodule

/* File: core/rom_host_ctrl.sv */
// host-side read controller for a mask rom with byte or word organisation
// Contract
// - hold chip enable high during power-up
// - wait 200 ns before first read
// - other inputs free during power wait
// - address settles within 10 ns while enabled
// - width pin high word, low byte
// - byte mode: top pin is address lsb
`timescale 1ns/1ps
module rom_host_ctrl
  import rom_host_pkg::*;
#(
  parameter logic [1:0] GATE_OPTION = GATE_OPT_LOW
)
(
  input wire logic CLK,                           // 10 MHz system clock
  input wire logic RESET_N,                       // async reset, active low
  input wire logic REQ,                           // read request, level
  input wire logic [BYTE_ADDR_W-1:0] REQ_ADDR,    // byte or word address
  input wire logic REQ_WIDTH,                     // 1 word read, 0 byte read
  output logic BUSY,                              // request not accepted
  output logic DONE,                              // one-cycle read done
  output logic [DATA_W-1:0] RDATA,                // read result
  output logic [ADDR_W-1:0] ADDR_BUS,             // rom address pins
  output logic CE_N,                              // rom chip enable
  output logic GATE,                              // rom output-gate pin
  output logic WIDTH_SEL,                         // rom width select pin
  input wire logic [LOW_W-1:0] LOW_DATA_BYTE,     // rom data bits 7..0
  input wire logic [UPPER_W-1:0] UPPER_DATA_PINS, // rom data bits 14..8
  input wire logic TOP_DATA_BIT_I,                // shared top pin, in
  output logic TOP_DATA_BIT_O,                    // shared top pin, out
  output logic TOP_DATA_BIT_OE                    // shared top pin, drive
);

  typedef struct packed {
    host_state_t state;
    logic [2:0] cnt;
    logic ce_n;
    logic gate;
    logic width;
    logic [ADDR_W-1:0] addr;
    logic top_o;
    logic top_oe;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic busy;
  } ctrl_t;

  ctrl_t st;
  ctrl_t next_st;
  logic [DATA_W-1:0] pins_synced;

  // gate levels for the fitted option; ignored parts get a quiet low
  logic gate_on;
  logic gate_off;
  assign gate_on = (GATE_OPTION == GATE_OPT_HIGH);
  assign gate_off = (GATE_OPTION == GATE_OPT_LOW);

  // data pins come from another chip, so they are synchronised first
  pin_sync u_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .pins({TOP_DATA_BIT_I, UPPER_DATA_PINS, LOW_DATA_BYTE}),
    .synced(pins_synced)
  );

  // sequencer: power wait, then one read at a time
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    case (st.state)
      ST_POWER: begin
        // enable stays high; other pins are free, so after the first edge the gate goes from its reset low to its off level
        next_st.ce_n = 1'b1;
        next_st.gate = gate_off;
        if (st.cnt == CNT_ONE) begin
          next_st.state = ST_IDLE;
          next_st.busy = 1'b0;
          next_st.cnt = CNT_ZERO;
        end else begin
          next_st.cnt = st.cnt - CNT_ONE;
        end
      end
      ST_IDLE: begin
        if (REQ) begin
          next_st.busy = 1'b1;
          next_st.state = ST_SETUP;
          next_st.width = REQ_WIDTH;
          if (REQ_WIDTH == WIDTH_WORD) begin
            next_st.addr = REQ_ADDR[ADDR_W-1:0];
            next_st.top_o = 1'b0;
            next_st.top_oe = 1'b0;
          end else begin
            // byte address: upper bits on the bus, lsb on the top pin
            next_st.addr = REQ_ADDR[BYTE_ADDR_W-1:1];
            next_st.top_o = REQ_ADDR[0];
            next_st.top_oe = 1'b1;
          end
        end
      end
      ST_SETUP: begin
        // all address pins changed one cycle earlier in one edge, so skew is nil
        next_st.ce_n = 1'b0;
        next_st.gate = gate_on;
        next_st.cnt = READ_WAIT_CYC;
        next_st.state = ST_ACCESS;
      end
      ST_ACCESS: begin
        if (st.cnt == CNT_ONE) begin
          if (st.width == WIDTH_WORD) begin
            next_st.rdata = pins_synced;
          end else begin
            next_st.rdata = {BYTE_PAD, pins_synced[LOW_W-1:0]};
          end
          next_st.done = 1'b1;
          next_st.ce_n = 1'b1;
          next_st.gate = gate_off;
          next_st.cnt = FLOAT_CYC;
          next_st.state = ST_RELEASE;
        end else begin
          next_st.cnt = st.cnt - CNT_ONE;
        end
      end
      ST_RELEASE: begin
        // let the rom float before a new cycle may turn the top pin round
        if (st.cnt == CNT_ONE) begin
          next_st.state = ST_IDLE;
          next_st.busy = 1'b0;
          next_st.cnt = CNT_ZERO;
        end else begin
          next_st.cnt = st.cnt - CNT_ONE;
        end
      end
      default: begin
        next_st.state = ST_IDLE;
        next_st.ce_n = 1'b1;
        next_st.gate = gate_off;
        next_st.busy = 1'b0;
      end
    endcase
  end

  // one register for the whole controller
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st.state <= ST_POWER;
      st.cnt <= POWER_WAIT_CYC;
      st.ce_n <= 1'b1;
      st.gate <= 1'b0;
      st.width <= WIDTH_WORD;
      st.addr <= ADDR_RST;
      st.top_o <= 1'b0;
      st.top_oe <= 1'b0;
      st.rdata <= DATA_RST;
      st.done <= 1'b0;
      st.busy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // every output is a field of the state register
  assign BUSY = st.busy;
  assign DONE = st.done;
  assign RDATA = st.rdata;
  assign ADDR_BUS = st.addr;
  assign CE_N = st.ce_n;
  assign GATE = st.gate;
  assign WIDTH_SEL = st.width;
  assign TOP_DATA_BIT_O = st.top_o;
  assign TOP_DATA_BIT_OE = st.top_oe;

  // power wait counter, helper for the checks below
  logic [2:0] up_cycles;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      up_cycles <= 3'h0;
    end else if (up_cycles != 3'h7) begin
      up_cycles <= up_cycles + 3'h1;
    end
  end

  a_ce_high_power: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st.state == ST_POWER) |-> CE_N)
    else $error("chip enable active during power wait");

  a_wait_first_read: assert property (@(posedge CLK) disable iff (!RESET_N)
    $fell(CE_N) |-> (up_cycles >= 3'(POWER_WAIT_CYC_I)))
    else $error("read started before power wait elapsed");

  a_addr_steady_ce: assert property (@(posedge CLK) disable iff (!RESET_N)
    (!CE_N && !$past(CE_N)) |-> ($stable(ADDR_BUS) && $stable(TOP_DATA_BIT_O)))
    else $error("address moved while chip enabled");

  a_width_steady_ce: assert property (@(posedge CLK) disable iff (!RESET_N)
    (!CE_N && !$past(CE_N)) |-> $stable(WIDTH_SEL))
    else $error("width select moved while chip enabled");

  a_word_top_float: assert property (@(posedge CLK) disable iff (!RESET_N)
    WIDTH_SEL |-> !TOP_DATA_BIT_OE)
    else $error("host drives top pin in word mode");

  a_byte_lsb_drive: assert property (@(posedge CLK) disable iff (!RESET_N)
    (!WIDTH_SEL && !CE_N) |-> TOP_DATA_BIT_OE)
    else $error("byte lsb not driven during byte read");

  a_read_length: assert property (@(posedge CLK) disable iff (!RESET_N)
    $fell(CE_N) |-> (!CE_N)[*3] ##1 (CE_N && DONE))
    else $error("read cycle length wrong");

  a_gate_levels: assert property (@(posedge CLK) disable iff (!RESET_N)
    (!CE_N |-> (GATE == gate_on)) and (CE_N && !BUSY |-> (GATE == gate_off)))
    else $error("gate pin at wrong level");

endmodule

/* File: tb/rom_model.sv */
// behavioural mask rom answering the host controller pins
`timescale 1ns/1ps
module rom_model
  import rom_host_pkg::*;
#(
  parameter logic [1:0] GATE_OPTION = GATE_OPT_LOW
)
(
  input wire logic [ADDR_W-1:0] addr_bus,      // address pins
  input wire logic ce_n,                       // chip enable, active low
  input wire logic gate,                       // output-gate pin
  input wire logic width_sel,                  // 1 word, 0 byte
  input wire logic top_in,                     // resolved shared top pin
  output logic [LOW_W-1:0] low_data_byte,      // data bits 7..0
  output logic [UPPER_W-1:0] upper_data_pins,  // data bits 14..8
  output logic top_out,                        // data bit 15
  output logic top_oe                          // high while driving top pin
);
  logic gate_on;
  logic drive;
  logic drive_late = 1'b0;
  logic [DATA_W-1:0] word;
  logic [LOW_W-1:0] low_now;
  logic [DATA_W-1:0] last = DATA_RST;
  // polarity of the gate pin is fixed per fitted option
  assign gate_on = (GATE_OPTION == GATE_OPT_LOW) ? !gate :
                   (GATE_OPTION == GATE_OPT_HIGH) ? gate : 1'b1;
  assign drive = !ce_n && gate_on;
  // contents depend on the address alone, nothing can write them
  assign word = {addr_bus[19:12] ^ 8'h5A, addr_bus[7:0]};
  assign low_now = (!width_sel && top_in) ? word[15:8] : word[7:0];
  // slow enough to catch a host that samples too early
  always @(drive)
    if (drive) drive_late <= #ACCESS_NS 1'b1;
    else drive_late <= #FLOAT_NS 1'b0;
  // released pins show the inverse, never a stale copy
  always @* begin
    if (drive_late) last[7:0] = low_now;
    if (drive_late && width_sel) last[15:8] = word[15:8];
  end
  assign low_data_byte = drive_late ? low_now : ~last[7:0];
  assign upper_data_pins = (drive_late && width_sel) ? word[14:8] : ~last[14:8];
  assign top_out = word[15];
  assign top_oe = drive_late && width_sel;
endmodule

/* File: tb/testbench.sv */
// self-checking bench: three controllers, one per gate option, each with a rom
`timescale 1ns/1ps
module testbench
  import rom_host_pkg::*;
;
  logic clk;
  logic reset_n = 1'b0;
  logic req = 1'b0;
  logic [BYTE_ADDR_W-1:0] req_addr = 21'h000000;
  logic req_width = 1'b1;
  wire [2:0] busy, done, ce_n, wsel, toe, tout;
  wire [DATA_W-1:0] rdata [3];
  int bad_count = 0;
  int comparisons = 0;
  // one controller and rom pair for each option
  for (genvar k = 0; k < 3; k++) begin : g
    logic [ADDR_W-1:0] addr_bus;
    logic gate, top_wire, m_top, m_oe;
    logic [LOW_W-1:0] low;
    logic [UPPER_W-1:0] upper;
    assign top_wire = toe[k] ? tout[k] : (m_oe ? m_top : ~tout[k]);
    rom_host_ctrl #(.GATE_OPTION(2'(k))) rom_host_ctrl_i (.CLK(clk), .RESET_N(reset_n),
      .REQ(req), .REQ_ADDR(req_addr), .REQ_WIDTH(req_width), .BUSY(busy[k]),
      .DONE(done[k]), .RDATA(rdata[k]), .ADDR_BUS(addr_bus), .CE_N(ce_n[k]),
      .GATE(gate), .WIDTH_SEL(wsel[k]), .LOW_DATA_BYTE(low), .UPPER_DATA_PINS(upper),
      .TOP_DATA_BIT_I(top_wire), .TOP_DATA_BIT_O(tout[k]), .TOP_DATA_BIT_OE(toe[k]));
    rom_model #(.GATE_OPTION(2'(k))) rom_model_i (.addr_bus(addr_bus), .ce_n(ce_n[k]),
      .gate(gate), .width_sel(wsel[k]), .top_in(top_wire), .low_data_byte(low),
      .upper_data_pins(upper), .top_out(m_top), .top_oe(m_oe));
  end
  // free-running system clock
  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [15:0] rom_word(input logic [19:0] a);
    return {a[19:12] ^ 8'h5A, a[7:0]};
  endfunction
  // reset, then enable must stay high through the power wait
  task automatic power_up;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check("ce wait a", ce_n, 3'h7);
    check("busy wait a", busy, 3'h7);
    check("width rst", wsel, 3'h7);
    @(negedge clk);
    check("ce wait b", ce_n, 3'h7);
    check("busy wait b", busy, 3'h7);
    @(negedge clk);
    check("busy free", busy, 3'h0);
  endtask
  // one read; poke raises a second request while busy that must be ignored
  task automatic read(input logic [20:0] a, input logic w, input logic poke);
    logic [15:0] wd;
    logic [15:0] exp;
    int n;
    wd = rom_word(w ? a[19:0] : a[20:1]);
    exp = w ? wd : {8'h00, a[0] ? wd[15:8] : wd[7:0]};
    @(negedge clk);
    while (busy[0] !== 1'b0) @(negedge clk);
    @(posedge clk);
    req <= 1'b1;
    req_addr <= a;
    req_width <= w;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    req <= poke;
    req_addr <= ~a;
    @(posedge clk);
    req <= 1'b0;
    n = 2;
    do begin
      @(negedge clk);
      n++;
      if (ce_n[0] === 1'b0) begin
        check("addr pins", 32'(g[0].addr_bus), 32'(w ? a[19:0] : a[20:1]));
        check("gate opt0", g[0].gate, 1'b0);
        check("gate opt1", g[1].gate, 1'b1);
        check("gate opt2", g[2].gate, 1'b0);
        check("width pin", wsel, {3{w}});
        check("top drive", toe, {3{!w}});
        if (!w) check("top lsb", tout, {3{a[0]}});
      end
    end while (done[0] !== 1'b1 && n < 12);
    check("done delay", 32'(n), 32'(READ_WAIT_CYC) + 32'd2);
    check("ce released", ce_n, 3'h7);
    for (int k = 0; k < 3; k++) check("rdata", rdata[k], exp);
    if (poke) repeat (8) begin
      @(negedge clk);
      check("no extra done", done, 3'h0);
    end
  endtask
  // hang guard
  initial begin
    #(CLK_PERIOD_NS * 400);
    bad_count++;
    stop_test();
  end
  // main sequence
  initial begin
    power_up();
    read(21'h000000, 1'b1, 1'b0);
    read(21'h0FFFFF, 1'b1, 1'b1);
    read(21'h1FFFFF, 1'b0, 1'b0);
    read(21'h02468A, 1'b0, 1'b1);
    read(21'h02468B, 1'b0, 1'b0);
    read(21'h0FFFFF, 1'b1, 1'b0);
    power_up();
    read(21'h0A5C3E, 1'b1, 1'b0);
    stop_test();
  end
endmodule
